// ==== shared/ccs_defs.svh ====
// Constants for the clock-tree control block: register offsets, field
// positions, reset values and source codes.
// Assumes inclusion by bare name from package and design files.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// Register offsets on the control port
`define CCS_OFS_DIV_RESETS     8'h0c
`define CCS_OFS_REF_AND_SRC    8'h0d
`define CCS_OFS_PIN_SELECT     8'h10

// Divider reset register fields
`define CCS_BIT_DSP_RUN        6
`define CCS_BIT_DAC_RUN        5
`define CCS_BIT_NCP_RUN        4
`define CCS_BIT_OSR_RUN        3
`define CCS_BIT_SYNC_RUN       2
`define CCS_BIT_BCK_RUN        1
`define CCS_BIT_WCK_RUN        0
`define CCS_RST_DIV_RESETS     8'h7d
`define CCS_MASK_DIV_RESETS    8'h7f

// Reference and processor source register fields
`define CCS_REF_MSB            6
`define CCS_REF_LSB            4
`define CCS_SRC_MSB            2
`define CCS_SRC_LSB            0
`define CCS_RST_REF_AND_SRC    8'h00
`define CCS_MASK_REF_AND_SRC   8'h77

// Processor clock pin select register field
`define CCS_PIN_MSB            6
`define CCS_PIN_LSB            4
`define CCS_RST_PIN_SELECT     8'h00
`define CCS_MASK_PIN_SELECT    8'h70

// Pin codes for the processor clock
`define CCS_PIN_GPIO0          3'h3
`define CCS_PIN_GPIO2          3'h5

`endif

// ==== shared/ccs_pkg.sv ====
// Types for the clock-tree control block.
// Assumes ccs_defs.svh is on the include path.
`default_nettype none
`include "ccs_defs.svh"

package ccs_pkg;

    typedef logic [7:0] ccs_byte_t;
    typedef logic [2:0] ccs_code_t;

    // Converter clock synchroniser state
    typedef enum logic [1:0] {
        CCS_SYNC_RUN,
        CCS_SYNC_HELD,
        CCS_SYNC_WAIT_FRAME
    } ccs_sync_t;

endpackage

`default_nettype wire

// ==== hw/ccs_clk_div.sv ====
// Clock divider driven by a sampled source level.
// Assumes the source is synchronous to ref_clk and slower than half of it.
`timescale 1ns/1ps
`default_nettype none

module ccs_clk_div #(
    parameter int HALF = 1
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic run,
    input  wire logic src_level,
    output logic      div_clk
);
    import ccs_pkg::*;

    localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

    if (HALF < 1)
    begin : g_bad_half
        $error("ccs_clk_div: HALF must be at least 1");
    end

    typedef struct packed {
        logic          src_d;
        logic [CW-1:0] cnt;
        logic          out;
    } ccs_div_state_t;

    ccs_div_state_t st_r;
    ccs_div_state_t st_nxt;

    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.src_d = src_level;
        if (!run)
        begin
            // Held divider parks low at once, so a high phase in progress is cut short
            st_nxt.cnt = '0;
            st_nxt.out = 1'b0;
        end
        else if (src_level && !st_r.src_d)
        begin
            if (st_r.cnt == CW'(HALF - 1))
            begin
                st_nxt.cnt = '0;
                st_nxt.out = !st_r.out;
            end
            else
            begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign div_clk = st_r.out;

endmodule

`default_nettype wire

// ==== hw/ccs_clock_ctrl.sv ====
// Clock-tree control: divider run controls, converter restart on frame,
// PLL reference select and processor clock source select.
// Assumes all clock inputs are slow levels synchronous to ref_clk and
// frame_start is a one-cycle pulse at the start of each audio frame.
`timescale 1ns/1ps
`default_nettype none

`include "ccs_defs.svh"

// Summary of operation
// - Bit 6 low holds processor divider in reset, clock stopped.
// - Bit 5 low holds converter divider reset, stopping dac_clk only.
// - Bit 4 low holds the NCP divider reset, clock stopped.
// - Bit 3 or 2 low resets synchroniser; converter clocks stop at once.
// - Release of bits 3 and 2 restarts converter clocks at frame start.
// - Bit 1 low holds master bit clock divider from master clock.
// - Bit 0 low holds master word clock divider from bit clock.
// - Reference code picks master, bit, oscillator, pin clock, else mute.
// - Automatic mode overrides the written PLL reference selection.
// - Processor source codes 000 to 101 pick sources; others mute.
// - Pin field 011 picks GPIO0, 101 picks GPIO2; others mute.
module ccs_clock_ctrl #(
    parameter int DSP_HALF = 1,
    parameter int DAC_HALF = 1,
    parameter int NCP_HALF = 1,
    parameter int BCK_HALF = 4,
    parameter int WCK_HALF = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire ccs_pkg::ccs_byte_t reg_addr,
    input  wire ccs_pkg::ccs_byte_t reg_wdata,
    output ccs_pkg::ccs_byte_t     reg_rdata,
    output logic                   reg_rvalid,
    input  wire logic              mclk_in,
    input  wire logic              sclk_in,
    input  wire logic              osc_in,
    input  wire logic              pll_clk_in,
    input  wire logic              gpio0_in,
    input  wire logic              gpio2_in,
    input  wire logic              dac_src_in,
    input  wire logic              ncp_src_in,
    input  wire logic              frame_start,
    input  wire logic              auto_mode,
    input  wire ccs_pkg::ccs_code_t auto_ref_code,
    input  wire logic              auto_master_clk,
    output logic                   pll_ref_clk,
    output logic                   dsp_clk,
    output logic                   dac_clk,
    output logic                   ncp_clk,
    output logic                   master_bck,
    output logic                   master_wck
);
    import ccs_pkg::*;

    if (DSP_HALF < 1 || DAC_HALF < 1 || NCP_HALF < 1 ||
        BCK_HALF < 1 || WCK_HALF < 1)
    begin : g_bad_half
        $error("ccs_clock_ctrl: divider half periods must be >= 1");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ccs_byte_t div_resets;
        ccs_byte_t ref_src;
        ccs_byte_t pin_sel;
        ccs_byte_t rdata;
        logic      rvalid;
        ccs_sync_t sync;
        ccs_code_t ref_cur;
        logic      ref_out;
        ccs_code_t src_cur;
        logic      src_out;
    } ccs_state_t;

    ccs_state_t st_r;
    ccs_state_t st_nxt;

    // Picks one level out of eight; index past the live sources reads 0
    function automatic logic pick_level(input logic [7:0] srcs,
                                        input ccs_code_t  idx);
        pick_level = srcs[idx];
    endfunction

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    ccs_code_t ref_code;
    ccs_code_t src_code;
    ccs_code_t pin_code;
    logic      dsp_pin_clk;
    logic      ref_level;
    logic      src_level;
    logic      ref_new;
    logic      src_new;
    logic      dsp_div_clk;

    always_comb
    begin
        ref_code = st_r.ref_src[`CCS_REF_MSB:`CCS_REF_LSB];
        if (auto_mode)
            ref_code = auto_ref_code;
        src_code = st_r.ref_src[`CCS_SRC_MSB:`CCS_SRC_LSB];
        pin_code = st_r.pin_sel[`CCS_PIN_MSB:`CCS_PIN_LSB];
        case (pin_code)
            `CCS_PIN_GPIO0: dsp_pin_clk = gpio0_in;
            `CCS_PIN_GPIO2: dsp_pin_clk = gpio2_in;
            default:        dsp_pin_clk = 1'b0;
        endcase
        // Reference uses the same pin field; the pin map is shared
        ref_level = pick_level({4'h0, dsp_pin_clk, osc_in, sclk_in,
                                mclk_in}, st_r.ref_cur);
        src_level = pick_level({2'h0, dsp_pin_clk, sclk_in, mclk_in,
                                osc_in, pll_clk_in, auto_master_clk},
                               st_r.src_cur);
        ref_new   = pick_level({4'h0, dsp_pin_clk, osc_in, sclk_in,
                                mclk_in}, ref_code);
        src_new   = pick_level({2'h0, dsp_pin_clk, sclk_in, mclk_in,
                                osc_in, pll_clk_in, auto_master_clk},
                               src_code);
    end

    // ------------------------------------------------------------------
    // Register port and sequencing
    // ------------------------------------------------------------------
    logic osr_run;
    logic sync_run;

    assign osr_run  = st_r.div_resets[`CCS_BIT_OSR_RUN];
    assign sync_run = st_r.div_resets[`CCS_BIT_SYNC_RUN];

    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.rvalid = reg_rd;
        if (reg_wr)
        begin
            case (reg_addr)
                `CCS_OFS_DIV_RESETS:
                    st_nxt.div_resets = reg_wdata & `CCS_MASK_DIV_RESETS;
                `CCS_OFS_REF_AND_SRC:
                    st_nxt.ref_src = reg_wdata & `CCS_MASK_REF_AND_SRC;
                `CCS_OFS_PIN_SELECT:
                    st_nxt.pin_sel = reg_wdata & `CCS_MASK_PIN_SELECT;
                default:
                    st_nxt.div_resets = st_r.div_resets;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                `CCS_OFS_DIV_RESETS:  st_nxt.rdata = st_r.div_resets;
                `CCS_OFS_REF_AND_SRC: st_nxt.rdata = st_r.ref_src;
                `CCS_OFS_PIN_SELECT:  st_nxt.rdata = st_r.pin_sel;
                default:              st_nxt.rdata = 8'h00;
            endcase
        end

        // Stop is immediate; restart waits for the next frame boundary
        case (st_r.sync)
            CCS_SYNC_RUN:
                if (!osr_run || !sync_run)
                    st_nxt.sync = CCS_SYNC_HELD;
            CCS_SYNC_HELD:
                if (osr_run && sync_run)
                    st_nxt.sync = CCS_SYNC_WAIT_FRAME;
            CCS_SYNC_WAIT_FRAME:
                if (!osr_run || !sync_run)
                    st_nxt.sync = CCS_SYNC_HELD;
                else if (frame_start)
                    st_nxt.sync = CCS_SYNC_RUN;
            default:
                st_nxt.sync = CCS_SYNC_HELD;
        endcase

        // Old clock finishes its high phase, output parks low, and the
        // move waits for the new level to be low: a low phase may stretch or
        // shrink, and a high phase is cut short only if the code returns to the old source first
        st_nxt.ref_out = ref_level;
        if (ref_code != st_r.ref_cur)
        begin
            st_nxt.ref_out = st_r.ref_out & ref_level;
            if (!st_r.ref_out && !ref_new)
                st_nxt.ref_cur = ref_code;
        end
        st_nxt.src_out = src_level;
        if (src_code != st_r.src_cur)
        begin
            st_nxt.src_out = st_r.src_out & src_level;
            if (!st_r.src_out && !src_new)
                st_nxt.src_cur = src_code;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_r            <= '0;
            st_r.div_resets <= `CCS_RST_DIV_RESETS;
            st_r.ref_src    <= `CCS_RST_REF_AND_SRC;
            st_r.pin_sel    <= `CCS_RST_PIN_SELECT;
            st_r.sync       <= CCS_SYNC_HELD;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    logic dsp_run;
    logic dac_run;
    logic ncp_run;
    logic bck_run;
    logic wck_run;
    logic conv_ok;

    assign conv_ok = (st_r.sync == CCS_SYNC_RUN);
    assign dsp_run = st_r.div_resets[`CCS_BIT_DSP_RUN];
    assign dac_run = st_r.div_resets[`CCS_BIT_DAC_RUN] && conv_ok;
    assign ncp_run = st_r.div_resets[`CCS_BIT_NCP_RUN] && conv_ok;
    assign bck_run = st_r.div_resets[`CCS_BIT_BCK_RUN];
    assign wck_run = st_r.div_resets[`CCS_BIT_WCK_RUN] && bck_run;

    ccs_clk_div #(.HALF(DSP_HALF)) u_dsp_div (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .run       (dsp_run),
        .src_level (st_r.src_out),
        .div_clk   (dsp_div_clk)
    );

    ccs_clk_div #(.HALF(DAC_HALF)) u_dac_div (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .run       (dac_run),
        .src_level (dac_src_in),
        .div_clk   (dac_clk)
    );

    ccs_clk_div #(.HALF(NCP_HALF)) u_ncp_div (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .run       (ncp_run),
        .src_level (ncp_src_in),
        .div_clk   (ncp_clk)
    );

    ccs_clk_div #(.HALF(BCK_HALF)) u_bck_div (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .run       (bck_run),
        .src_level (mclk_in),
        .div_clk   (master_bck)
    );

    ccs_clk_div #(.HALF(WCK_HALF)) u_wck_div (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .run       (wck_run),
        .src_level (master_bck),
        .div_clk   (master_wck)
    );

    assign dsp_clk     = dsp_div_clk;
    assign pll_ref_clk = st_r.ref_out;
    assign reg_rdata   = st_r.rdata;
    assign reg_rvalid  = st_r.rvalid;

endmodule

`default_nettype wire

// ==== bench/ccs_src_model.sv ====
// Clock sources and audio frame marker feeding the clock-tree block.
// Assumes one ref_clk domain; all levels change just after its edge.
`timescale 1ns/1ps
`default_nettype none
module ccs_src_model (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic slow,
    output logic      mclk_in,
    output logic      sclk_in,
    output logic      osc_in,
    output logic      pll_clk_in,
    output logic      gpio0_in,
    output logic      gpio2_in,
    output logic      frame_start
);
    logic [7:0] cnt_r;
    logic       step_r;
    // Slow mode halves every rate; frame marker stays one cycle wide
    always_ff @(posedge ref_clk)
    begin
        step_r <= srst | ~slow | ~step_r;
        if (srst)
            cnt_r <= 8'h00;
        else if (step_r)
            cnt_r <= cnt_r + 8'h01;
    end
    assign mclk_in     = cnt_r[1];
    assign sclk_in     = cnt_r[2];
    assign osc_in      = cnt_r[3];
    assign pll_clk_in  = cnt_r[4];
    assign gpio0_in    = cnt_r[5];
    assign gpio2_in    = cnt_r[6];
    assign frame_start = step_r & (cnt_r == 8'h00);
endmodule
`default_nettype wire

// ==== bench/ccs_clock_ctrl_props.sv ====
// Checker for the clock-tree block, bound to its top module.
// Assumes writes land in the registers on the edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_props (
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire logic               reg_wr,
    input wire ccs_pkg::ccs_byte_t reg_addr,
    input wire ccs_pkg::ccs_byte_t reg_wdata,
    input wire logic               frame_start,
    input wire logic               dsp_clk,
    input wire logic               dac_clk,
    input wire logic               ncp_clk,
    input wire logic               master_bck,
    input wire logic               master_wck,
    input wire logic               pll_ref_clk
);
    import ccs_pkg::*;
    ccs_byte_t r;
    logic      held;
    logic      wt;
    // Shadow of the reset register and of the synchroniser wait
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            r <= 8'h7d;
        else if (reg_wr && reg_addr == 8'h0c)
            r <= reg_wdata & 8'h7f;
        if (srst || !r[3] || !r[2])
        begin
            held <= 1'b1;
            wt   <= 1'b0;
        end
        else if (!wt)
            wt <= 1'b1;
        else if (frame_start)
            held <= 1'b0;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    dsp_halt_a: assert property ((!r[6]) [*3] |-> !dsp_clk)
        else $error("dsp clock not held");
    dac_halt_a: assert property ((!r[5]) [*3] |-> !dac_clk)
        else $error("dac clock not held");
    ncp_halt_a: assert property ((!r[4]) [*3] |-> !ncp_clk)
        else $error("ncp clock not held");
    sync_stop_a: assert property ((!r[3] || !r[2]) [*3]
        |-> !dac_clk && !ncp_clk) else $error("sync held clocks run");
    frame_wait_a: assert property (held |=> !dac_clk)
        else $error("dac clock before frame");
    restart_a: assert property ($fell(held) && r[5]
        |-> ##[1:16] dac_clk) else $error("dac clock no restart");
    bck_halt_a: assert property ((!r[1]) [*3] |-> !master_bck)
        else $error("bit clock not held");
    wck_halt_a: assert property ((!r[0]) [*3] |-> !master_wck)
        else $error("word clock not held");
    ref_no_runt_a: assert property ($rose(pll_ref_clk)
        |=> pll_ref_clk) else $error("reference high phase cut short");
    cover property ($fell(held));
    cover property (reg_wr && reg_addr == 8'h0d);
    cover property ($rose(master_wck));
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_props chk (.ref_clk, .srst, .reg_wr,
    .reg_addr, .reg_wdata, .frame_start, .dsp_clk, .dac_clk, .ncp_clk,
    .master_bck, .master_wck, .pll_ref_clk);
`default_nettype wire

// ==== bench/ccs_clock_ctrl_tb.sv ====
// Self-checking bench for the clock-tree block: register access, divider
// resets and source selection, judged by output clock periods.
// Assumes the source model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
module ccs_clock_ctrl_tb;
    import ccs_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
    localparam int REF_P[8] = '{4, 8, 16, 64, 0, 0, 0, 0};
    localparam int DSP_P[8] = '{32, 64, 32, 8, 16, 128, 0, 0};
    localparam int OUT_I[7] = '{1, 2, 3, 2, 2, 4, 5};
    localparam int RUN_P[6] = '{4, 32, 8, 16, 32, 128};
    logic ref_clk, srst, reg_wr, reg_rd, reg_rvalid, auto_mode, slow;
    logic mclk_in, sclk_in, osc_in, pll_clk_in, gpio0_in, gpio2_in;
    logic frame_start, pll_ref_clk, dsp_clk, dac_clk, ncp_clk;
    logic master_bck, master_wck;
    logic [5:0] outs;
    ccs_byte_t reg_addr, reg_wdata, reg_rdata, d;
    ccs_code_t auto_ref_code;
    int fails, comparisons, p, b, c;
    assign outs = {master_wck, master_bck, ncp_clk, dac_clk, dsp_clk,
                   pll_ref_clk};
    ccs_src_model src (.ref_clk, .srst, .slow, .mclk_in, .sclk_in,
        .osc_in, .pll_clk_in, .gpio0_in, .gpio2_in, .frame_start);
    ccs_clock_ctrl #(.BCK_HALF(4), .WCK_HALF(2)) uut (.ref_clk, .srst,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
        .mclk_in, .sclk_in, .osc_in, .pll_clk_in, .gpio0_in, .gpio2_in,
        .dac_src_in(mclk_in), .ncp_src_in(sclk_in), .frame_start,
        .auto_mode, .auto_ref_code, .auto_master_clk(osc_in), .pll_ref_clk,
        .dsp_clk, .dac_clk, .ncp_clk, .master_bck, .master_wck);
    task results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Write leaves one idle cycle so strobes never merge
    task wr(input ccs_byte_t a, input ccs_byte_t v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        @(posedge ref_clk) #1;
    endtask
    task rd(input ccs_byte_t a, output ccs_byte_t v);
        int k;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++)
            @(posedge ref_clk) #1;
        if (k == 4)
        begin
            fails++;
            results();
        end
        v = reg_rdata;
    endtask
    // Period between two rising edges; 0 if the clock stays stopped
    task meas(input int i, output int q);
        logic o;
        int n, s;
        q = 0;
        s = -1;
        o = outs[i];
        for (n = 0; n < 700; n++)
        begin
            @(posedge ref_clk) #1;
            if (outs[i] === 1'b1 && o !== 1'b1)
            begin
                if (s >= 0)
                begin
                    q = n - s;
                    break;
                end
                s = n;
            end
            o = outs[i];
        end
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        {srst, reg_wr, reg_rd, auto_mode, slow} = 5'h10;
        {reg_addr, reg_wdata, auto_ref_code} = 19'h0;
        repeat (3) @(posedge ref_clk);
        #1 srst = 1'b0;
        rd(8'h0c, d); `CHK(d, 8'h7d)
        rd(8'h0d, d); `CHK(d, 8'h00)
        wr(8'h20, 8'hff); rd(8'h20, d); `CHK(d, 8'h00)
        meas(4, p); `CHK(p, 0)
        wr(8'h0c, 8'h7f);
        meas(4, p); `CHK(p, 32)
        meas(5, p); `CHK(p, 128)
        $display("test reset done");
        for (b = 6; b >= 0; b--)
        begin
            wr(8'h0c, ~(8'h01 << b) & 8'h7f);
            meas(OUT_I[6-b], p); `CHK(p, 0)
            wr(8'h0c, 8'h7f);
            meas(OUT_I[6-b], p); `CHK(p, RUN_P[OUT_I[6-b]])
        end
        $display("test divider resets done");
        wr(8'h10, 8'h30);
        for (c = 0; c < 8; c++)
        begin
            wr(8'h0d, 8'(c << 4));
            meas(0, p); `CHK(p, REF_P[c])
            wr(8'h0d, 8'(c));
            meas(1, p); `CHK(p, DSP_P[c])
        end
        wr(8'h10, 8'h50); wr(8'h0d, 8'h05);
        meas(1, p); `CHK(p, 256)
        wr(8'h10, 8'h10);
        meas(1, p); `CHK(p, 0)
        rd(8'h10, d); `CHK(d, 8'h10)
        $display("test source select done");
        slow = 1'b1;
        auto_ref_code = 3'h1;
        auto_mode = 1'b1;
        wr(8'h0d, 8'h00);
        meas(0, p); `CHK(p, 16)
        auto_mode = 1'b0;
        meas(0, p); `CHK(p, 8)
        $display("test auto mode done");
        results();
    end
endmodule
`default_nettype wire
